// [rtl/timer_pkg.sv]
// constants shared by the timer core and its channel
package timer_pkg;
  localparam int NUM_TIMERS = 3;
  // register map, per timer: index = timer*8 + offset
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_CTRL1 = 3'h1;
  localparam logic [2:0] OFS_CNT_L = 3'h2;
  localparam logic [2:0] OFS_CNT_H = 3'h3;
  localparam logic [2:0] OFS_CMPA_L = 3'h4;
  localparam logic [2:0] OFS_CMPA_H = 3'h5;
  localparam logic [2:0] OFS_CMPP_L = 3'h6;
  localparam logic [2:0] OFS_CMPP_H = 3'h7;
  localparam logic [4:0] ADDR_FLAGS = 5'h18;
  localparam logic [4:0] ADDR_PINSEL = 5'h19;
  localparam logic [4:0] ADDR_TIMER_END = 5'h18;
  // field positions
  localparam int CTRL0_PAUSE = 7;
  localparam int CTRL0_CLK_LO = 4;
  localparam int CTRL0_EN = 3;
  localparam int CTRL0_CAPSRC = 1;
  localparam int CTRL1_MODE_LO = 6;
  localparam int CTRL1_IO_LO = 4;
  localparam int CTRL1_OUTINIT = 3;
  localparam int CTRL1_POL = 2;
  localparam int CTRL1_DPX = 1;
  localparam int CTRL1_CCLR = 0;
  localparam int FLAGS_P_LO = 3;
  // reset values and write masks
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL0_MASK = 8'hFA;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [5:0] PINSEL_RST = 6'h00;
  // clock select codes
  localparam logic [2:0] CLK_SYS4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_HIGH16 = 3'h2;
  localparam logic [2:0] CLK_HIGH64 = 3'h3;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;
  // operating modes and io codes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [1:0] IO_CAP_RISE = 2'h0;
  localparam logic [1:0] IO_CAP_FALL = 2'h1;
  localparam logic [1:0] IO_CAP_BOTH = 2'h2;
  localparam logic [1:0] IO_PWM_ACTIVE = 2'h1;
  localparam logic [1:0] IO_PWM_RUN = 2'h2;
  localparam logic [1:0] IO_SINGLE = 2'h3;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } chan_state_t;
endpackage

// [rtl/timer_channel.sv]
// one timer: counter, comparators, output and capture logic
`timescale 1ns/100ps
`default_nettype none
module timer_channel
  import timer_pkg::*;
#(
  parameter bit HAS_CAPTURE = 1'b0,
  parameter bit HAS_PULSE = 1'b0,
  parameter bit EXT_CAPTURE = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // count enable and synchronised pin edges
  input wire logic tick,
  input wire logic extRise,
  input wire logic extFall,
  input wire logic capRise,
  input wire logic capFall,
  // configuration
  input wire logic enable,
  input wire logic pause,
  input wire logic capFromExt,
  input wire logic [1:0] mode,
  input wire logic [1:0] io,
  input wire logic outInit,
  input wire logic dutyPeriod,
  input wire logic clearOnA,
  input wire logic [15:0] cmpA,
  input wire logic [15:0] cmpP,
  // results
  output logic [15:0] count,
  output logic matchA,
  output logic matchP,
  output logic capEvent,
  output logic out
);
  chan_state_t state_r;
  logic [15:0] count_r;
  logic out_r;
  logic spMode, trigger, hit, clrHit, srcRise, srcFall, capEdge;
  logic [15:0] period, duty;

  assign spMode = HAS_PULSE && mode == MODE_PWM && io == IO_SINGLE;
  assign trigger = state_r == ST_WAIT && enable && extRise;
  assign hit = state_r == ST_RUN && enable && !pause && tick;
  assign matchA = hit && count_r == cmpA;
  assign matchP = hit && count_r == cmpP;
  // edge-aligned pwm: one compare sets the period, the other the duty
  assign period = (mode == MODE_PWM) ? (dutyPeriod ? cmpA : cmpP) : (clearOnA ? cmpA : cmpP);
  assign duty = dutyPeriod ? cmpP : cmpA;
  assign clrHit = hit && count_r == period && !spMode;
  assign srcRise = (EXT_CAPTURE && capFromExt) ? extRise : capRise;
  assign srcFall = (EXT_CAPTURE && capFromExt) ? extFall : capFall;
  assign capEdge = (srcRise && (io == IO_CAP_RISE || io == IO_CAP_BOTH))
                || (srcFall && (io == IO_CAP_FALL || io == IO_CAP_BOTH));
  assign capEvent = HAS_CAPTURE && mode == MODE_CAPTURE && state_r == ST_RUN && enable && capEdge;
  assign count = count_r;
  assign out = out_r;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: if (enable) state_r <= spMode ? ST_WAIT : ST_RUN;
        ST_WAIT: begin
          if (!enable) state_r <= ST_OFF;
          else if (trigger) state_r <= ST_RUN;
        end
        ST_RUN: begin
          if (!enable) state_r <= ST_OFF;
          else if (spMode && matchA) state_r <= ST_WAIT;
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // counter keeps its value while off or paused
  always_ff @(posedge ref_clk) begin
    if (!rst_n) count_r <= 16'h0000;
    else if (state_r == ST_OFF && enable) count_r <= 16'h0000;
    else if (trigger) count_r <= 16'h0000;
    else if (clrHit) count_r <= 16'h0000;
    else if (hit) count_r <= count_r + 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) out_r <= 1'b0;
    else if (state_r == ST_OFF && enable) out_r <= (mode == MODE_PWM) ? !outInit : outInit;
    else if (mode == MODE_CMP) begin
      if (matchA) begin
        case (io)
          IO_LOW: out_r <= 1'b0;
          IO_HIGH: out_r <= 1'b1;
          IO_TOGGLE: out_r <= !out_r;
          default: out_r <= out_r;
        endcase
      end
    end else if (mode == MODE_PWM) begin
      if (spMode) begin
        if (trigger) out_r <= outInit;
        else if (matchA) out_r <= !outInit;
      end else begin
        case (io)
          IO_PWM_ACTIVE: out_r <= outInit;
          IO_PWM_RUN: out_r <= (count_r < duty) ? outInit : !outInit;
          default: out_r <= !outInit;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_ENABLE_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_OFF && enable) |=> (count_r == 16'h0000 && state_r != ST_OFF))
    else $error("counter not cleared on enable");
  AST_COUNT_UP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (hit && !clrHit && !(spMode && matchA)) |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not advance by one");
  AST_MATCH_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode != MODE_PWM && (clearOnA ? matchA : matchP)) |=> count_r == 16'h0000)
    else $error("period match did not clear counter");
  AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode == MODE_CMP && io == IO_TOGGLE && matchA) |=> out_r != $past(out_r))
    else $error("compare output did not toggle");
endmodule // timer_channel
`default_nettype wire

// [rtl/timer_module_common_core.sv]
// three timer modules (compact, standard, periodic) with register port and pins
// Behaviour
// - each timer runs a free count-up counter compared with programmed values
// - a compare match flags an interrupt, may clear counter, may change output
// - each timer has separate interrupt sources for comparator A and comparator P
// - three-bit clock select picks system ratio, high clock, sub clock or ext pin
// - ext pin clock counts on rising or falling edge as configured
// - standard and periodic single pulse mode use ext clock pin as trigger
// - standard and periodic capture edge selects rising, falling or both
// - periodic capture can take its ext clock pin instead of capture pin
// - two output pins per timer, second always inverse of the first
// - compare match output mode drives output high, low or toggles on match
// - pwm waveform appears on the same output pins as compare output
// - outputs reach a pin only when its pin-sharing selection is set
// - high byte read directly, low byte only through a shared 8-bit buffer
// - compare low write fills buffer; compare high write stores high and copies buffer to low
// - high read returns high and latches low into buffer; low read returns buffer
// - one edge-aligned pwm channel, duty or period adjustable
// - compact timer: 16-bit counter, compare, timer and pwm, no capture or pulse
// - exactly three timers: one compact, one standard, one periodic
// - counter clears when enable rises; software cannot alter it otherwise
`timescale 1ns/100ps
`default_nettype none
module timer_module_common_core
  import timer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // input pins: ext clock index 0 compact, 1 standard, 2 periodic; capture index 0 standard, 1 periodic
  input wire logic subClockPin,
  input wire logic [2:0] extClockPin,
  input wire logic [1:0] capturePin,
  // output pins
  output logic [2:0] timerOut,
  output logic [2:0] timerOutInverted,
  output logic [2:0] timerOutEn,
  output logic [2:0] timerOutInvertedEn,
  // comparator interrupt requests
  output logic [2:0] irqA,
  output logic [2:0] irqP
);
  logic [7:0] ctrl0_r [NUM_TIMERS];
  logic [7:0] ctrl1_r [NUM_TIMERS];
  logic [15:0] cmpA_r [NUM_TIMERS];
  logic [15:0] cmpP_r [NUM_TIMERS];
  logic [7:0] hold_r [NUM_TIMERS];
  logic [15:0] count [NUM_TIMERS];
  logic [5:0] pinSel_r;
  logic [2:0] flagA_r;
  logic [2:0] flagP_r;
  logic [5:0] pre_r;
  logic [5:0] syncA_r;
  logic [5:0] syncB_r;
  logic [5:0] syncC_r;
  logic [7:0] regRdData_r;
  logic [2:0] timerOut_r;
  logic [2:0] timerOutInv_r;
  logic [2:0] timerOutEn_r;
  logic [2:0] timerOutInvEn_r;
  logic [2:0] matchA;
  logic [2:0] matchP;
  logic [2:0] capEvent;
  logic [2:0] chOut;
  logic [2:0] tick;
  logic [2:0] extRise;
  logic [2:0] extFall;
  logic [2:0] capRise;
  logic [2:0] capFall;
  logic subRise;
  logic tick4, tick16, tick64;
  logic flagClr;

  ////////////////////////////////////////////////////////////////////////
  // address decode for one timer register
  function automatic logic regHit(input logic [4:0] a, input int t, input logic [2:0] o);
    logic [1:0] tIdx;
    tIdx = t[1:0];
    return a == {tIdx, o};
  endfunction

  // count enable from the clock select field; high clock is the core clock here
  function automatic logic selTick(input logic [2:0] sel, input logic t4, input logic t16,
                                   input logic t64, input logic sub, input logic rise,
                                   input logic fall);
    case (sel)
      CLK_SYS4: return t4;
      CLK_SYS: return 1'b1;
      CLK_HIGH16: return t16;
      CLK_HIGH64: return t64;
      CLK_EXT_RISE: return rise;
      CLK_EXT_FALL: return fall;
      default: return sub;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bits 2..0 ext clock, 4..3 capture, 5 sub clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncA_r <= 6'h00;
      syncB_r <= 6'h00;
      syncC_r <= 6'h00;
    end else begin
      syncA_r <= {subClockPin, capturePin, extClockPin};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  assign extRise = syncB_r[2:0] & ~syncC_r[2:0];
  assign extFall = ~syncB_r[2:0] & syncC_r[2:0];
  assign capRise = {syncB_r[4:3] & ~syncC_r[4:3], 1'b0};
  assign capFall = {~syncB_r[4:3] & syncC_r[4:3], 1'b0};
  assign subRise = syncB_r[5] & ~syncC_r[5];

  // shared prescaler for the divided clock ratios
  always_ff @(posedge ref_clk) begin
    if (!rst_n) pre_r <= 6'h00;
    else pre_r <= pre_r + 6'h01;
  end

  assign tick4 = pre_r[1:0] == 2'h3;
  assign tick16 = pre_r[3:0] == 4'hF;
  assign tick64 = pre_r == 6'h3F;

  ////////////////////////////////////////////////////////////////////////
  // compact has no capture or pulse; only periodic may capture from its clock pin
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : gTimer
    assign tick[g] = selTick(ctrl0_r[g][CTRL0_CLK_LO +: 3], tick4, tick16, tick64, subRise,
                             extRise[g], extFall[g]);
    timer_channel #(
      .HAS_CAPTURE(g != 0),
      .HAS_PULSE(g != 0),
      .EXT_CAPTURE(g == 2)
    ) uChan (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick[g]),
      .extRise(extRise[g]),
      .extFall(extFall[g]),
      .capRise(capRise[g]),
      .capFall(capFall[g]),
      .enable(ctrl0_r[g][CTRL0_EN]),
      .pause(ctrl0_r[g][CTRL0_PAUSE]),
      .capFromExt(ctrl0_r[g][CTRL0_CAPSRC]),
      .mode(ctrl1_r[g][CTRL1_MODE_LO +: 2]),
      .io(ctrl1_r[g][CTRL1_IO_LO +: 2]),
      .outInit(ctrl1_r[g][CTRL1_OUTINIT]),
      .dutyPeriod(ctrl1_r[g][CTRL1_DPX]),
      .clearOnA(ctrl1_r[g][CTRL1_CCLR]),
      .cmpA(cmpA_r[g]),
      .cmpP(cmpP_r[g]),
      .count(count[g]),
      .matchA(matchA[g]),
      .matchP(matchP[g]),
      .capEvent(capEvent[g]),
      .out(chOut[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctrl0_r[i] <= CTRL_RST;
        ctrl1_r[i] <= CTRL_RST;
      end
    end else if (regWrEn) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (regHit(regAddr, i, OFS_CTRL0)) ctrl0_r[i] <= regWrData & CTRL0_MASK;
        if (regHit(regAddr, i, OFS_CTRL1)) ctrl1_r[i] <= regWrData;
      end
    end
  end

  // compare registers; a capture wins over a software write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        cmpA_r[i] <= CMP_RST;
        cmpP_r[i] <= CMP_RST;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (capEvent[i]) cmpA_r[i] <= count[i];
        else if (regWrEn && regHit(regAddr, i, OFS_CMPA_H)) cmpA_r[i] <= {regWrData, hold_r[i]};
        if (regWrEn && regHit(regAddr, i, OFS_CMPP_H)) cmpP_r[i] <= {regWrData, hold_r[i]};
      end
    end
  end

  // one holding buffer per timer, shared by all its register pairs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TIMERS; i++) hold_r[i] <= 8'h00;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (regWrEn && (regHit(regAddr, i, OFS_CMPA_L) || regHit(regAddr, i, OFS_CMPP_L)))
          hold_r[i] <= regWrData;
        if (regRdEn && regHit(regAddr, i, OFS_CNT_H)) hold_r[i] <= count[i][7:0];
        if (regRdEn && regHit(regAddr, i, OFS_CMPA_H)) hold_r[i] <= cmpA_r[i][7:0];
        if (regRdEn && regHit(regAddr, i, OFS_CMPP_H)) hold_r[i] <= cmpP_r[i][7:0];
      end
    end
  end

  assign flagClr = regWrEn && regAddr == ADDR_FLAGS;

  // sticky flags, write one to clear; a new match beats the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flagA_r <= 3'h0;
      flagP_r <= 3'h0;
    end else begin
      flagA_r <= (flagA_r & ~({3{flagClr}} & regWrData[2:0])) | matchA | capEvent;
      flagP_r <= (flagP_r & ~({3{flagClr}} & regWrData[FLAGS_P_LO +: 3])) | matchP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) pinSel_r <= PINSEL_RST;
    else if (regWrEn && regAddr == ADDR_PINSEL) pinSel_r <= regWrData[5:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // read data valid only in the cycle after the strobe; counter is read-only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) regRdData_r <= 8'h00;
    else begin
      regRdData_r <= 8'h00;
      if (regRdEn) begin
        if (regAddr == ADDR_FLAGS) regRdData_r <= {2'h0, flagP_r, flagA_r};
        else if (regAddr == ADDR_PINSEL) regRdData_r <= {2'h0, pinSel_r};
        else if (regAddr < ADDR_TIMER_END) begin
          case (regAddr[2:0])
            OFS_CTRL0: regRdData_r <= ctrl0_r[regAddr[4:3]];
            OFS_CTRL1: regRdData_r <= ctrl1_r[regAddr[4:3]];
            OFS_CNT_H: regRdData_r <= count[regAddr[4:3]][15:8];
            OFS_CMPA_H: regRdData_r <= cmpA_r[regAddr[4:3]][15:8];
            OFS_CMPP_H: regRdData_r <= cmpP_r[regAddr[4:3]][15:8];
            default: regRdData_r <= hold_r[regAddr[4:3]];
          endcase
        end
      end
    end
  end

  // pins: polarity applied, inverse pin derived, enables follow pin-sharing selection
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timerOut_r <= 3'h0;
      timerOutInv_r <= 3'h7;
      timerOutEn_r <= 3'h0;
      timerOutInvEn_r <= 3'h0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        timerOut_r[i] <= chOut[i] ^ ctrl1_r[i][CTRL1_POL];
        timerOutInv_r[i] <= !(chOut[i] ^ ctrl1_r[i][CTRL1_POL]);
      end
      timerOutEn_r <= pinSel_r[2:0];
      timerOutInvEn_r <= pinSel_r[5:3];
    end
  end

  assign regRdData = regRdData_r;
  assign timerOut = timerOut_r;
  assign timerOutInverted = timerOutInv_r;
  assign timerOutEn = timerOutEn_r;
  assign timerOutInvertedEn = timerOutInvEn_r;
  assign irqA = flagA_r;
  assign irqP = flagP_r;

  ////////////////////////////////////////////////////////////////////////
  AST_INVERSE_PIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timerOutInverted == ~timerOut)
    else $error("inverted output not the inverse");
  AST_MATCH_P_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (matchP[0] && !flagClr) |=> irqP[0]
      && irqA[0] == ($past(irqA[0]) || $past(matchA[0] || capEvent[0])))
    else $error("P match did not raise its own flag");
  AST_FLAG_HOLDS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (flagA_r[1] && !(flagClr && regWrData[1])) |=> flagA_r[1])
    else $error("flag lost without a clear");
  AST_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrEn && regAddr == {2'h0, OFS_CMPA_L}) |=> hold_r[0] == $past(regWrData)
      && cmpA_r[0] == $past(cmpA_r[0]))
    else $error("low write did not only fill the buffer");
  AST_HIGH_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrEn && regAddr == {2'h0, OFS_CMPA_H}) |=> cmpA_r[0] == {$past(regWrData), $past(hold_r[0])})
    else $error("high write did not pair with buffer");
  AST_HIGH_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regRdEn && regAddr == {2'h0, OFS_CNT_H}) |=> regRdData == $past(count[0][15:8])
      && hold_r[0] == $past(count[0][7:0]))
    else $error("high read did not latch low byte");
  AST_PIN_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pinSel_r[0] |=> !timerOutEn[0])
    else $error("output enabled without pin selection");
  AST_PIN_INV_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pinSel_r[3] |=> !timerOutInvertedEn[0])
    else $error("inverted output enabled without pin selection");
  AST_MATCH_A_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    matchA[0] |=> irqA[0])
    else $error("A match did not raise its flag");
  AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (flagClr && regWrData[0] && !matchA[0] && !capEvent[0]) |=> !irqA[0])
    else $error("flag not cleared by software");
  AST_P_FLAG_HOLDS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (flagP_r[0] && !(flagClr && regWrData[FLAGS_P_LO])) |=> flagP_r[0])
    else $error("P flag lost without a clear");
  AST_LOW_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regRdEn && regAddr == {2'h0, OFS_CNT_L}) |=> regRdData == $past(hold_r[0]))
    else $error("low read did not return the buffer");
  AST_CMPP_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrEn && regAddr == {2'h1, OFS_CMPP_H}) |=> cmpP_r[1] == {$past(regWrData), $past(hold_r[1])})
    else $error("P high write did not pair with buffer");
  AST_CMPA_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regRdEn && regAddr == {2'h1, OFS_CMPA_H}) |=> hold_r[1] == $past(cmpA_r[1][7:0]))
    else $error("A high read did not latch low byte");
  AST_CAPTURE_COPY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    capEvent[1] |=> cmpA_r[1] == $past(count[1]) && irqA[1])
    else $error("capture did not store the count");
  AST_EXT_SOURCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ctrl0_r[2][CTRL0_CAPSRC] && !capRise[2] && !capFall[2]) |-> !capEvent[2])
    else $error("capture taken from the wrong pin");
  AST_CMP_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (matchA[0] && ctrl1_r[0][CTRL1_IO_LO +: 4] == {MODE_CMP, IO_HIGH} && !ctrl1_r[0][CTRL1_POL])
    |=> ##1 timerOut[0])
    else $error("compare match did not drive output high");
  AST_COUNT_READ_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrEn && regAddr == {2'h0, OFS_CNT_H} && !tick[0] && $past(ctrl0_r[0][CTRL0_EN]))
    |=> count[0] == $past(count[0]))
    else $error("software write altered the counter");
endmodule // timer_module_common_core
`default_nettype wire

// [testbench/timer_pin_model.sv]
// pin model for the external clock and capture inputs of the timers
`timescale 1ns/100ps
`default_nettype none
module timer_pin_model (
  // clock
  input wire logic ref_clk,
  // pins driven towards the timers
  output var logic [2:0] extClockPin,
  output var logic [1:0] capturePin
);
  // pins rest low between events, as a pull-down would hold them
  initial begin
    extClockPin = 3'h0;
    capturePin = 2'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // width sets a prompt or a slow pulse; the trailing settle keeps checks off the edge
  task automatic ext_pulse(input int idx, input int width);
    @(posedge ref_clk);
    extClockPin[idx] <= 1'b1;
    repeat (width) @(posedge ref_clk);
    extClockPin[idx] <= 1'b0;
    repeat (width) @(posedge ref_clk);
    #1;
  endtask
  task automatic cap_level(input int idx, input logic v);
    @(posedge ref_clk);
    capturePin[idx] <= v;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
endmodule // timer_pin_model
`default_nettype wire

// [testbench/tb_timer_module_common_core.sv]
// self-checking bench: register pairs, counting, compare outputs and capture
`timescale 1ns/100ps
`default_nettype none
module tb_timer_module_common_core;
  import timer_pkg::*;
  logic ref_clk;
  logic rst_n;
  logic regWrEn;
  logic regRdEn;
  logic subClockPin;
  logic [4:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic [2:0] extClockPin;
  logic [1:0] capturePin;
  logic [2:0] timerOut;
  logic [2:0] timerOutInverted;
  logic [2:0] timerOutEn;
  logic [2:0] timerOutInvertedEn;
  logic [2:0] irqA;
  logic [2:0] irqP;
  int fail_count = 0;
  int samples_checked = 0;
  logic [1:0] ioTab [3] = '{IO_LOW, IO_HIGH, IO_TOGGLE};
  logic [1:0] capTab [3] = '{IO_CAP_RISE, IO_CAP_FALL, IO_CAP_BOTH};
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  timer_module_common_core u_dut (.ref_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .subClockPin, .extClockPin, .capturePin, .timerOut, .timerOutInverted,
    .timerOutEn, .timerOutInvertedEn, .irqA, .irqP);
  timer_pin_model u_pins (.ref_clk, .extClockPin, .capturePin);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] ra(input int t, input logic [2:0] o);
    return {2'(t), o};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // each access starts on its own edge, so a gap cycle separates strobes
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    finish_test;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    regAddr = 5'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    subClockPin = 1'b0;
    rst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk(timerOutInverted, 3'h7);
    chk(timerOutEn, 3'h0);
    rd(ADDR_FLAGS, 8'h00);
    rd(ra(2, OFS_CTRL1), 8'h00);
    $display("test reset done");
    // low writes share one buffer, so the later one lands in both pairs
    for (int t = 0; t < NUM_TIMERS; t++) begin
      wr(ra(t, OFS_CMPA_L), 8'h34);
      wr(ra(t, OFS_CMPP_L), 8'h56);
      wr(ra(t, OFS_CMPA_H), 8'h12);
      wr(ra(t, OFS_CMPP_H), 8'h12);
      rd(ra(t, OFS_CMPA_H), 8'h12);
      rd(ra(t, OFS_CNT_L), 8'h56);
      rd(ra(t, OFS_CNT_H), 8'h00);
      rd(ra(t, OFS_CMPP_L), 8'h00);
      rd(ra(t, OFS_CMPP_H), 8'h12);
      rd(ra(t, OFS_CMPP_L), 8'h56);
    end
    wr(5'h1A, 8'hFF);
    rd(5'h1A, 8'h00);
    $display("test register pairs done");
    wr(ra(0, OFS_CTRL0), 8'h68);
    repeat (5) u_pins.ext_pulse(0, 2);
    rd(ra(0, OFS_CNT_H), 8'h00);
    rd(ra(0, OFS_CNT_L), 8'h05);
    wr(ra(0, OFS_CTRL0), 8'h00);
    wr(ra(0, OFS_CTRL0), 8'h78);
    repeat (2) u_pins.ext_pulse(0, 6);
    wr(ra(0, OFS_CNT_H), 8'hFF);
    rd(ra(0, OFS_CNT_H), 8'h00);
    rd(ra(0, OFS_CNT_L), 8'h02);
    $display("test external counting done");
    wr(ra(0, OFS_CMPA_L), 8'h02);
    wr(ra(0, OFS_CMPA_H), 8'h00);
    wr(ra(0, OFS_CMPP_L), 8'h01);
    wr(ra(0, OFS_CMPP_H), 8'h00);
    wr(ADDR_PINSEL, 8'h09);
    for (int i = 0; i < 3; i++) begin
      wr(ra(0, OFS_CTRL0), 8'h00);
      wr(ADDR_FLAGS, 8'h3F);
      wr(ra(0, OFS_CTRL1), {MODE_CMP, ioTab[i], i == 0, 3'h1});
      wr(ra(0, OFS_CTRL0), 8'h68);
      repeat (2) u_pins.ext_pulse(0, 3);
      chk(irqP, 3'h1);
      chk(irqA, 3'h0);
      chk(timerOut[0], i == 0);
      u_pins.ext_pulse(0, 3);
      chk(irqA, 3'h1);
      chk(timerOut[0], i > 0);
      chk(timerOutInverted[0], i == 0);
      chk({timerOutInvertedEn, timerOutEn}, 6'h09);
      repeat (3) u_pins.ext_pulse(0, 3);
      chk(timerOut[0], i == 1);
      wr(ADDR_FLAGS, 8'h01);
      rd(ADDR_FLAGS, 8'h08);
    end
    // pwm with period on A (2) and duty on P (1): active only while the count is 0
    wr(ra(0, OFS_CTRL0), 8'h00);
    wr(ra(0, OFS_CTRL1), {MODE_PWM, IO_PWM_RUN, 4'hA});
    wr(ra(0, OFS_CTRL0), 8'h68);
    u_pins.ext_pulse(0, 3);
    chk(timerOut[0], 1'b0);
    repeat (2) u_pins.ext_pulse(0, 3);
    chk(timerOut[0], 1'b1);
    $display("test compare output done");
    // sub clock held still, so the counter cannot match while capturing
    for (int j = 0; j < 3; j++) begin
      wr(ra(1, OFS_CTRL0), 8'h00);
      wr(ADDR_FLAGS, 8'h3F);
      wr(ra(1, OFS_CTRL1), {MODE_CAPTURE, capTab[j], 4'h0});
      wr(ra(1, OFS_CTRL0), 8'h48);
      u_pins.cap_level(0, 1'b1);
      chk(irqA[1], j != 1);
      u_pins.cap_level(0, 1'b0);
      chk(irqA[1], 1'b1);
    end
    rd(ra(1, OFS_CMPA_H), 8'h00);
    wr(ra(2, OFS_CTRL1), {MODE_CAPTURE, IO_CAP_RISE, 4'h0});
    wr(ra(2, OFS_CTRL0), 8'h48);
    u_pins.ext_pulse(2, 3);
    chk(irqA[2], 1'b0);
    wr(ra(2, OFS_CTRL0), 8'h4A);
    u_pins.ext_pulse(2, 3);
    chk(irqA[2], 1'b1);
    // periodic timer still counts sub clock rising edges: three of them
    repeat (6) begin
      repeat (4) @(posedge ref_clk);
      subClockPin <= ~subClockPin;
    end
    rd(ra(2, OFS_CNT_H), 8'h00);
    rd(ra(2, OFS_CNT_L), 8'h03);
    $display("test capture done");
    finish_test;
  end
endmodule // tb_timer_module_common_core
`default_nettype wire
